// ---- verilog/cvr_consts.svh ----
`ifndef CVR_CONSTS_SVH
`define CVR_CONSTS_SVH
// Register byte offsets
`define CVR_OFF_CTRL    8'h00
`define CVR_OFF_STATUS  8'h04
`define CVR_OFF_POS     8'h08
`define CVR_OFF_NEG     8'h0c
`define CVR_OFF_DESC    8'h10
// Upper address nibble of the register groups
`define CVR_GRP_RXMAP   4'h2
`define CVR_GRP_TXMAP   4'h3
`define CVR_GRP_THR     4'h4
// Result store
`define CVR_FIFO_DEPTH  16
`define CVR_PTR_W       4
`define CVR_CNT_W       10
// Control fields and reset value
`define CVR_CTRL_STORE  23
`define CVR_CTRL_LVL    8
`define CVR_CTRL_IEN    0
`define CVR_LEVEL_RST   10'h200
// Status fields
`define CVR_ST_FULL     31
`define CVR_ST_WM       30
`define CVR_ST_EMPTY    29
`define CVR_ST_CNT      16
// Descriptor result word fields
`define CVR_DW_TX       27
`define CVR_DW_ID       24
`define CVR_DW_RX       19
// Threshold field position
`define CVR_THR_LSB     8
`endif

// ---- verilog/cvr_pkg.sv ----
package cvr_pkg;
	// Result handed in by the scan engine, one cycle wide
	typedef struct packed {
		logic        valid;
		logic [1:0]  desc_id;
		logic [4:0]  tx_index;
		logic [4:0]  rx_index;
		logic [11:0] pos;
		logic [11:0] neg;
	} cvr_result_t;
	// Per-descriptor events from the scan engine
	typedef struct packed {
		logic [3:0] trigger;
		logic [3:0] done;
		logic [3:0] busy;
	} cvr_desc_evt_t;
	// One stored result
	typedef struct packed {
		logic [4:0]  tx_index;
		logic [4:0]  rx_index;
		logic [1:0]  desc_id;
		logic [17:0] delta;
		logic [11:0] pos;
		logic [11:0] neg;
	} cvr_entry_t;
	// Four 6-bit selectors per register, four registers
	typedef logic [3:0][3:0][5:0] cvr_map_t;
endpackage

// ---- verilog/cvr_fifo.sv ----
`timescale 1ns/10ps
`include "cvr_consts.svh"
module cvr_fifo (
	input  wire logic                   pclk,
	input  wire logic                   presetn,
	input  wire logic                   push,
	input  cvr_pkg::cvr_entry_t         push_data,
	input  wire logic                   pop,
	output cvr_pkg::cvr_entry_t         head,
	output logic [`CVR_CNT_W-1:0]       count,
	output logic                        full,
	output logic                        empty
);
	import cvr_pkg::*;

	cvr_entry_t                mem_reg [`CVR_FIFO_DEPTH];  // Entry storage
	logic [`CVR_PTR_W-1:0]     wr_ptr_reg;                 // Next slot to fill
	logic [`CVR_PTR_W-1:0]     rd_ptr_reg;                 // Oldest entry
	logic [`CVR_CNT_W-1:0]     cnt_reg;                    // Words held
	logic                      do_push;                    // Push accepted
	logic                      do_pop;                     // Pop accepted
	logic [`CVR_CNT_W-1:0]     cnt_next;                   // Count after edge

	// A push while full is dropped; nothing stored moves
	assign do_push  = push & ~full;
	assign do_pop   = pop & ~empty;
	assign cnt_next = cnt_reg + `CVR_CNT_W'(do_push) - `CVR_CNT_W'(do_pop);
	assign full     = (cnt_reg == `CVR_CNT_W'(`CVR_FIFO_DEPTH));
	assign empty    = (cnt_reg == '0);
	assign count    = cnt_reg;
	assign head     = mem_reg[rd_ptr_reg];

	// Pointers and count
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			cnt_reg    <= '0;
		end else begin
			wr_ptr_reg <= wr_ptr_reg + `CVR_PTR_W'(do_push);
			rd_ptr_reg <= rd_ptr_reg + `CVR_PTR_W'(do_pop);
			cnt_reg    <= cnt_next;
		end
	end

	// Storage has no reset; entries are only read once counted
	always_ff @(posedge pclk) begin
		if (do_push) begin
			mem_reg[wr_ptr_reg] <= push_data;
		end
	end
endmodule

// ---- verilog/cvr_top.sv ----
// Behaviour
// - Full flag high while store holds maximum
// - Watermark high once count reaches level setting
// - Empty flag high while store holds nothing
// - Status shows ten-bit word count
// - Hardware sets descriptor interrupt flag; software clears
// - Done set on completion, cleared by trigger
// - Busy mirrors the engine busy input one cycle later
// - Positive read shows head positive sum
// - Negative read shows head negative sum
// - Descriptor word carries first TX index
// - Descriptor word carries first RX index
// - Descriptor word names producing descriptor
// - Descriptor word carries negative minus positive
// - Reading descriptor word pops the store
// - RX maps: four byte-aligned six-bit selectors
// - TX maps: four byte-aligned six-bit selectors
// - Unimplemented bits read zero, ignore writes
// - Ten-bit level setting drives the watermark
// - Store mode keeps only results exceeding threshold
// - Descriptor threshold compared with the difference
`timescale 1ns/10ps
`include "cvr_consts.svh"
module cvr_top (
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [7:0]        paddr,
	input  wire logic [31:0]       pwdata,
	output logic [31:0]            prdata,
	output logic                   pready,
	output logic                   pslverr,
	input  cvr_pkg::cvr_result_t   result_in,
	input  cvr_pkg::cvr_desc_evt_t desc_evt,
	input  wire logic [4:0]        scan_rx_index,
	input  wire logic [4:0]        scan_tx_index,
	output logic [5:0]             rx_channel_select,
	output logic [5:0]             tx_channel_select
);
	import cvr_pkg::*;

	// Selector for an index; indexes beyond the map read channel zero
	function automatic logic [5:0] chan_pick(input cvr_map_t m, input logic [4:0] i);
		chan_pick = i[4] ? 6'h00 : m[i[3:2]][i[1:0]];
	endfunction

	// Software-visible state
	logic                   threshold_store_mode_reg;  // Keep only exceeding results
	logic [9:0]             fifo_level_setting_reg;    // Watermark level
	logic [3:0]             desc_irq_en_reg;           // Per-descriptor flag enables
	cvr_map_t               rx_map_reg;                // RX channel selectors
	cvr_map_t               tx_map_reg;                // TX channel selectors
	logic [3:0][23:0]       descriptor_threshold_reg;  // Per-descriptor threshold
	logic [3:0]             desc_irq_flag_reg;         // Sticky interrupt flags
	logic [3:0]             desc_done_flag_reg;        // Completed since last trigger
	logic [3:0]             desc_busy_flag_reg;        // In progress
	// Bus answer and channel selector registers
	logic [31:0]            prdata_reg;
	logic                   pready_reg;
	logic                   pslverr_reg;
	logic [5:0]             rx_sel_reg;
	logic [5:0]             tx_sel_reg;

	// Bus phase decode
	logic                   setup_ph;                  // Setup cycle
	logic                   acc_done;                  // Completing access edge
	logic                   wr_done;                   // Write takes effect
	logic                   aligned;                   // Word aligned address
	logic                   hit_ctrl;
	logic                   hit_stat;
	logic                   hit_pos;
	logic                   hit_neg;
	logic                   hit_desc;
	logic                   hit_rx;
	logic                   hit_tx;
	logic                   hit_thr;
	logic                   addr_ok;                   // Mapped register
	logic [1:0]             wr_idx;                    // Register index in group

	assign setup_ph = psel & ~penable;
	assign acc_done = psel & penable & pready_reg;
	assign wr_done  = acc_done & pwrite;
	assign aligned  = (paddr[1:0] == 2'h0);
	assign wr_idx   = paddr[3:2];
	assign hit_ctrl = (paddr == `CVR_OFF_CTRL);
	assign hit_stat = (paddr == `CVR_OFF_STATUS);
	assign hit_pos  = (paddr == `CVR_OFF_POS);
	assign hit_neg  = (paddr == `CVR_OFF_NEG);
	assign hit_desc = (paddr == `CVR_OFF_DESC);
	assign hit_rx   = aligned & (paddr[7:4] == `CVR_GRP_RXMAP);
	assign hit_tx   = aligned & (paddr[7:4] == `CVR_GRP_TXMAP);
	assign hit_thr  = aligned & (paddr[7:4] == `CVR_GRP_THR);
	assign addr_ok  = hit_ctrl | hit_stat | hit_pos | hit_neg | hit_desc
		| hit_rx | hit_tx | hit_thr;

	// Result store path
	cvr_entry_t             new_entry;                 // Entry built from input
	cvr_entry_t             head;                      // Oldest stored entry
	logic [17:0]            delta;                     // Negative minus positive
	logic                   exceeds;                   // Difference above threshold
	logic                   push;                      // Offer to the store
	logic                   pop;                       // Descriptor word read done
	logic [`CVR_CNT_W-1:0]  fifo_word_count;
	logic                   fifo_full_flag;
	logic                   fifo_empty_flag;
	logic                   fifo_watermark_flag;

	assign delta = {6'h00, result_in.neg} - {6'h00, result_in.pos};
	assign exceeds = $signed({{6{delta[17]}}, delta})
		> $signed(descriptor_threshold_reg[result_in.desc_id]);
	assign push = result_in.valid & (~threshold_store_mode_reg | exceeds);
	assign pop  = acc_done & ~pwrite & hit_desc;

	// Indexes and descriptor kept per entry
	assign new_entry.tx_index = result_in.tx_index;
	assign new_entry.rx_index = result_in.rx_index;
	assign new_entry.desc_id  = result_in.desc_id;
	assign new_entry.delta    = delta;
	assign new_entry.pos      = result_in.pos;
	assign new_entry.neg      = result_in.neg;

	cvr_fifo u_fifo (
		.pclk      (pclk),
		.presetn   (presetn),
		.push      (push),
		.push_data (new_entry),
		.pop       (pop),
		.head      (head),
		.count     (fifo_word_count),
		.full      (fifo_full_flag),
		.empty     (fifo_empty_flag)
	);

	assign fifo_watermark_flag = (fifo_word_count >= fifo_level_setting_reg);

	// Read words; fields beyond the documented widths stay zero
	logic [31:0]            ctrl_word;
	logic [31:0]            stat_word;
	logic [31:0]            pos_word;
	logic [31:0]            neg_word;
	logic [31:0]            desc_word;
	logic [31:0]            map_word;
	logic [31:0]            thr_word;
	logic [31:0]            rd_mux;
	logic [3:0][5:0]        map_sel;                   // Addressed map register

	assign ctrl_word = (32'(threshold_store_mode_reg) << `CVR_CTRL_STORE)
		| (32'(fifo_level_setting_reg) << `CVR_CTRL_LVL)
		| (32'(desc_irq_en_reg) << `CVR_CTRL_IEN);
	assign stat_word = (32'(fifo_full_flag) << `CVR_ST_FULL)
		| (32'(fifo_watermark_flag) << `CVR_ST_WM)
		| (32'(fifo_empty_flag) << `CVR_ST_EMPTY)
		| (32'(fifo_word_count) << `CVR_ST_CNT)
		| 32'({desc_irq_flag_reg[3], desc_done_flag_reg[3], desc_busy_flag_reg[3], 1'b0,
			desc_irq_flag_reg[2], desc_done_flag_reg[2], desc_busy_flag_reg[2], 1'b0,
			desc_irq_flag_reg[1], desc_done_flag_reg[1], desc_busy_flag_reg[1], 1'b0,
			desc_irq_flag_reg[0], desc_done_flag_reg[0], desc_busy_flag_reg[0]});
	// Head sums; an empty store reads zero
	assign pos_word  = fifo_empty_flag ? 32'h0 : 32'(head.pos);
	assign neg_word  = fifo_empty_flag ? 32'h0 : 32'(head.neg);
	assign desc_word = fifo_empty_flag ? 32'h0 :
		(32'(head.tx_index) << `CVR_DW_TX) | (32'(head.desc_id) << `CVR_DW_ID)
		| (32'(head.rx_index) << `CVR_DW_RX) | 32'(head.delta);
	assign map_sel   = hit_rx ? rx_map_reg[wr_idx] : tx_map_reg[wr_idx];
	// Two top bits of each byte read zero
	assign map_word  = {2'h0, map_sel[3], 2'h0, map_sel[2], 2'h0, map_sel[1],
		2'h0, map_sel[0]};
	assign thr_word  = 32'(descriptor_threshold_reg[wr_idx]) << `CVR_THR_LSB;
	assign rd_mux    = hit_ctrl ? ctrl_word :
		hit_stat ? stat_word :
		hit_pos ? pos_word :
		hit_neg ? neg_word :
		hit_desc ? desc_word :
		(hit_rx | hit_tx) ? map_word :
		hit_thr ? thr_word : 32'h0;

	// Answer registered from the setup cycle: no wait states
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_reg  <= 1'b0;
			prdata_reg  <= 32'h0;
			pslverr_reg <= 1'b0;
		end else begin
			pready_reg  <= setup_ph;
			prdata_reg  <= (setup_ph & ~pwrite) ? rd_mux : 32'h0;
			pslverr_reg <= setup_ph & ~addr_ok;
		end
	end

	// Control register; only documented fields are kept
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			threshold_store_mode_reg <= 1'b0;
			fifo_level_setting_reg   <= `CVR_LEVEL_RST;
			desc_irq_en_reg          <= 4'h0;
		end else if (wr_done & hit_ctrl) begin
			threshold_store_mode_reg <= pwdata[`CVR_CTRL_STORE];
			fifo_level_setting_reg   <= pwdata[`CVR_CTRL_LVL +: 10];
			desc_irq_en_reg          <= pwdata[`CVR_CTRL_IEN +: 4];
		end
	end

	// Maps and thresholds
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_map_reg               <= '0;
			tx_map_reg               <= '0;
			descriptor_threshold_reg <= '0;
		end else begin
			for (int k = 0; k < 4; k++) begin
				// RX byte k holds index 4n+k
				if (wr_done & hit_rx) begin
					rx_map_reg[wr_idx][k] <= pwdata[8*k +: 6];
				end
				// TX byte k holds index 4n+k
				if (wr_done & hit_tx) begin
					tx_map_reg[wr_idx][k] <= pwdata[8*k +: 6];
				end
			end
			if (wr_done & hit_thr) begin
				descriptor_threshold_reg[wr_idx] <= pwdata[`CVR_THR_LSB +: 24];
			end
		end
	end

	// Descriptor flags; a hardware set wins over a same-cycle clear
	logic [3:0]             irq_set;
	logic [3:0]             irq_keep;
	logic [3:0]             stat_irq_wr;               // Written irq bit values

	assign stat_irq_wr = {pwdata[14], pwdata[10], pwdata[6], pwdata[2]};
	assign irq_keep    = (wr_done & hit_stat) ? stat_irq_wr : 4'hf;
	assign irq_set     = (result_in.valid & exceeds) ?
		(desc_irq_en_reg & (4'h1 << result_in.desc_id)) : 4'h0;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			desc_irq_flag_reg  <= 4'h0;
			desc_done_flag_reg <= 4'h0;
			desc_busy_flag_reg <= 4'h0;
		end else begin
			desc_irq_flag_reg  <= irq_set | (desc_irq_flag_reg & irq_keep);
			desc_done_flag_reg <= desc_evt.done | (desc_done_flag_reg & ~desc_evt.trigger);
			desc_busy_flag_reg <= desc_evt.busy;
		end
	end

	// Channel selectors for the current scan position
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_sel_reg <= 6'h00;
			tx_sel_reg <= 6'h00;
		end else begin
			rx_sel_reg <= chan_pick(rx_map_reg, scan_rx_index);
			tx_sel_reg <= chan_pick(tx_map_reg, scan_tx_index);
		end
	end

	assign prdata            = prdata_reg;
	assign pready            = pready_reg;
	assign pslverr           = pslverr_reg;
	assign rx_channel_select = rx_sel_reg;
	assign tx_channel_select = tx_sel_reg;

	// Checks
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	property p_full;
		stat_word[31] == (fifo_word_count == `CVR_CNT_W'(`CVR_FIFO_DEPTH));
	endproperty
	a_full: assert property (p_full) else $error("full flag mismatch");

	property p_wm;
		stat_word[30] == (fifo_word_count >= fifo_level_setting_reg);
	endproperty
	a_wm: assert property (p_wm) else $error("watermark mismatch");

	property p_empty;
		stat_word[29] |-> fifo_word_count == 10'd0 && pos_word == 32'h0;
	endproperty
	a_empty: assert property (p_empty) else $error("empty flag mismatch");

	property p_irq;
		result_in.valid && exceeds && desc_irq_en_reg[result_in.desc_id]
		|=> desc_irq_flag_reg[$past(result_in.desc_id)];
	endproperty
	a_irq: assert property (p_irq) else $error("irq flag not set");

	property p_done;
		desc_evt.trigger[0] && !desc_evt.done[0] |=> !desc_done_flag_reg[0];
	endproperty
	a_done: assert property (p_done) else $error("done not cleared");

	property p_busy;
		desc_busy_flag_reg == $past(desc_evt.busy);
	endproperty
	a_busy: assert property (p_busy) else $error("busy mismatch");

	property p_pop;
		pop && !fifo_empty_flag && !push
		|=> fifo_word_count == $past(fifo_word_count) - 10'd1;
	endproperty
	a_pop: assert property (p_pop) else $error("pop missed");

	property p_drop;
		fifo_full_flag && !pop |=> fifo_word_count == 10'd16 ##1 1'b1;
	endproperty
	a_drop: assert property (p_drop) else $error("full store changed");

	property p_store;
		result_in.valid && threshold_store_mode_reg && !exceeds && !pop
		|=> $stable(fifo_word_count);
	endproperty
	a_store: assert property (p_store) else $error("filtered result stored");

	property p_rsvd;
		setup_ph && !pwrite && (hit_pos || hit_neg) |=> prdata[31:12] == 20'h0;
	endproperty
	a_rsvd: assert property (p_rsvd) else $error("reserved bits set");

	c_full: cover property (fifo_full_flag && result_in.valid);
	c_pop: cover property (pop && !fifo_empty_flag);
	c_clr: cover property (wr_done && hit_stat && |irq_set);
	c_wm: cover property (fifo_watermark_flag && !fifo_full_flag);
endmodule

// ---- test/cvr_top_tb.sv ----
`timescale 1ns/10ps
`include "cvr_consts.svh"
module cvr_top_tb;
	import cvr_pkg::*;
	// Bus, result and scan-position stimulus
	logic          pclk;
	logic          presetn;
	logic          psel;
	logic          penable;
	logic          pwrite;
	logic [7:0]    paddr;
	logic [31:0]   pwdata;
	logic [31:0]   prdata;
	logic          pready;
	logic          pslverr;
	cvr_result_t   result_in;
	cvr_desc_evt_t desc_evt;
	logic [4:0]    scan_rx_index;
	logic [4:0]    scan_tx_index;
	logic [5:0]    rx_channel_select;
	logic [5:0]    tx_channel_select;
	// Last read answer
	logic [31:0]   rd_data;
	logic          rd_err;
	logic [3:0]    m;
	int            n_fail;
	int            total_checks;

	cvr_top dut_u (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .result_in(result_in),
		.desc_evt(desc_evt), .scan_rx_index(scan_rx_index),
		.scan_tx_index(scan_tx_index), .rx_channel_select(rx_channel_select),
		.tx_channel_select(tx_channel_select)
	);

	// Free-running 125 MHz clock
	initial pclk = 1'b0;
	always #4 pclk = ~pclk;

	// Compare and count
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			$display("wrong value %s expected %h seen %h", nm, e, g);
			n_fail++;
		end
	endtask

	// One APB transfer; waits for pready rather than assuming a latency
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		chk("pready", 32'h1, {31'h0, pready});
		rd_data = prdata;
		rd_err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// Read and compare, expecting an OKAY response
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
		apb(1'b0, a, 32'h0);
		chk(nm, e, rd_data);
		chk("slverr", 32'h0, {31'h0, rd_err});
	endtask

	// One-cycle result pulse; the idle cycle after it keeps valid from being driven twice
	task automatic push(input logic [1:0] id, input logic [4:0] tx, input logic [4:0] rx,
		input logic [11:0] p, input logic [11:0] n);
		@(posedge pclk);
		result_in <= '{1'b1, id, tx, rx, p, n};
		@(posedge pclk);
		result_in.valid <= 1'b0;
	endtask

	// Entry i contents, chosen so deltas take both signs
	function automatic logic [11:0] epos(input int i);
		return {i[3:0], 8'h21};
	endfunction
	function automatic logic [11:0] eneg(input int i);
		return {~i[3:0], 8'h43};
	endfunction
	function automatic logic [31:0] edesc(input int i);
		logic [17:0] dl;
		dl = {6'h0, eneg(i)} - {6'h0, epos(i)};
		return {i[4:0], 1'b0, i[1:0], ~i[4:0], 1'b0, dl};
	endfunction
	// Status for n stored words with level setting 3 and no descriptor flags
	function automatic logic [31:0] est(input int n);
		return {n == 16, n >= 3, n == 0, 3'b0, n[9:0], 16'h0};
	endfunction

	// Verdict and end of run
	task automatic summarize;
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// Watchdog, far beyond the few hundred cycles the tests need
	initial begin
		#160000;
		n_fail++;
		$display("wrong value watchdog expected done seen hang");
		summarize();
	end

	initial begin
		{psel, penable, pwrite, paddr, pwdata} = '0;
		presetn = 1'b0;
		result_in = '0;
		desc_evt = '0;
		scan_rx_index = 5'h0;
		scan_tx_index = 5'h0;
		n_fail = 0;
		total_checks = 0;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		// Reset state of status, control and an empty store
		rd(`CVR_OFF_STATUS, 32'h2000_0000, "status");
		rd(`CVR_OFF_CTRL, 32'h0002_0000, "ctrl");
		rd(`CVR_OFF_DESC, 32'h0, "desc empty");
		rd(8'h20, 32'h0, "rx map rst");
		// Unmapped and unaligned places are refused
		apb(1'b1, 8'h14, 32'hffff_ffff);
		apb(1'b0, 8'h14, 32'h0);
		chk("slverr", 32'h1, {31'h0, rd_err});
		chk("prdata", 32'h0, rd_data);
		apb(1'b0, 8'h21, 32'h0);
		chk("slverr", 32'h1, {31'h0, rd_err});
		// Channel maps: upper two bits of each byte are dropped
		apb(1'b1, 8'h24, 32'heaeb_eced);
		apb(1'b1, 8'h3c, 32'hc1c2_c3c4);
		rd(8'h24, 32'h2a2b_2c2d, "rx map");
		rd(8'h3c, 32'h0102_0304, "tx map");
		scan_rx_index <= 5'd6;
		scan_tx_index <= 5'd15;
		repeat (3) @(posedge pclk);
		chk("rx sel", 32'h2b, {26'h0, rx_channel_select});
		chk("tx sel", 32'h01, {26'h0, tx_channel_select});
		// Fill past full with level setting 3
		apb(1'b1, `CVR_OFF_CTRL, 32'h0000_0300);
		rd(`CVR_OFF_CTRL, 32'h0000_0300, "ctrl");
		for (int i = 0; i < 17; i++) begin
			push(i[1:0], i[4:0], ~i[4:0], epos(i), eneg(i));
			rd(`CVR_OFF_STATUS, est(i < 16 ? i + 1 : 16), "status");
		end
		// Drain in order; the dropped seventeenth entry must never show
		for (int i = 0; i < 16; i++) begin
			rd(`CVR_OFF_POS, {20'h0, epos(i)}, "pos");
			rd(`CVR_OFF_NEG, {20'h0, eneg(i)}, "neg");
			rd(`CVR_OFF_DESC, edesc(i), "desc");
			rd(`CVR_OFF_STATUS, est(15 - i), "status");
		end
		rd(`CVR_OFF_DESC, 32'h0, "desc empty");
		rd(`CVR_OFF_STATUS, est(0), "status");
		// Store mode, descriptor threshold and interrupt flag
		apb(1'b1, 8'h44, 32'h0000_64ff);
		rd(8'h44, 32'h0000_6400, "thr");
		apb(1'b1, `CVR_OFF_CTRL, 32'h0080_0302);
		push(2'd1, 5'd3, 5'd4, 12'd0, 12'd50);
		push(2'd1, 5'd3, 5'd4, 12'd0, 12'd200);
		push(2'd0, 5'd1, 5'd2, 12'd9, 12'd5);
		rd(`CVR_OFF_STATUS, 32'h0001_0040, "status");
		apb(1'b1, `CVR_OFF_STATUS, 32'h0000_0040);
		rd(`CVR_OFF_STATUS, 32'h0001_0040, "irq kept");
		apb(1'b1, `CVR_OFF_STATUS, 32'h0);
		rd(`CVR_OFF_STATUS, 32'h0001_0000, "irq clr");
		rd(`CVR_OFF_DESC, {5'd3, 1'b0, 2'd1, 5'd4, 1'b0, 18'd200}, "desc");
		// Busy, done and trigger for each descriptor
		for (int k = 0; k < 4; k++) begin
			m = 4'h1 << k;
			@(posedge pclk);
			desc_evt <= '{4'h0, 4'h0, m};
			repeat (2) @(posedge pclk);
			rd(`CVR_OFF_STATUS, 32'h2000_0000 | (32'h1 << (4 * k)), "busy");
			@(posedge pclk);
			desc_evt <= '{4'h0, m, 4'h0};
			@(posedge pclk);
			desc_evt <= '0;
			repeat (2) @(posedge pclk);
			rd(`CVR_OFF_STATUS, 32'h2000_0000 | (32'h2 << (4 * k)), "done");
			@(posedge pclk);
			desc_evt <= '{m, 4'h0, 4'h0};
			@(posedge pclk);
			desc_evt <= '0;
			repeat (2) @(posedge pclk);
			rd(`CVR_OFF_STATUS, 32'h2000_0000, "done clr");
		end
		summarize();
	end
endmodule
